//--- hdl/passive_serial_config_sequencer.sv
// Passive serial configuration sequencer with its word FIFO
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------------------
// Summary of operation
// RL1 - Host holds the request low at least 2 us to start reconfiguration.
// RL2 - Complete pin driven low within 600 ns of the request falling.
// RL3 - Status pin driven low within 600 ns of the request falling.
// RL4 - Status stays low 268 us to 1506 us unless extended externally.
// RL5 - Status released within 1506 us after the request returns high.
// RL6 - Data accepted only once status and request are both released high.
// RL7 - Host waits 2 us after status rises before the first clock edge.
// RL8 - Host ignoring status waits 1506 us after the request rises.
// RL9 - Data sampled on config clock rising edges, at most 125 MHz.
// RL10 - Oscillator initialization reaches user mode 175 to 437 us after completion.
// RL11 - User clock enabled after 4 clock periods; 8576 periods more to user mode.
// RL12 - Initialization clocked by oscillator, user start-up clock or config clock; the code has no config clock option.
// RL13 - User start-up clock is an option; otherwise the default source is used.
// RL14 - Complete stays low during data and rises only after error-free bitstream.
// ------------------------------------------------------------------------------

// ------------------------------------------------------------------------------
// Word FIFO, single clock
// ------------------------------------------------------------------------------
module pscfg_word_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;
  wire ptr_msb_diff = wr_ptr_ff[AW] != rd_ptr_ff[AW];
  wire ptr_low_same = wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0];

  // Full and empty from the wrap bit of the pointers
  assign o_ready = !(ptr_msb_diff && ptr_low_same);
  assign o_valid = !(!ptr_msb_diff && ptr_low_same);
  assign o_data = mem_ff[rd_ptr_ff[AW-1:0]];

  // Storage needs no reset; only words behind valid are ever read
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= i_data;
    end
  end

  // Pointers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
      rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
    end
  end
endmodule : pscfg_word_fifo

// ------------------------------------------------------------------------------
// Sequencer top
// ------------------------------------------------------------------------------
module passive_serial_config_sequencer #(
  parameter int unsigned WORD_W = pscfg_pkg::WORD_W,
  parameter int unsigned FIFO_DEPTH = pscfg_pkg::FIFO_DEPTH,
  parameter int unsigned BITSTREAM_WORDS = pscfg_pkg::BITSTREAM_WORDS,
  parameter int unsigned USER_INIT_CYCLES = pscfg_pkg::USER_INIT_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_CONFIG_CLOCK,
  input wire logic I_DATA,
  input wire logic I_CONFIG_REQUEST_N,
  input wire logic I_STATUS_N,
  output logic O_STATUS_N,
  output logic O_STATUS_N_OE,
  input wire logic I_CONFIG_COMPLETE,
  output logic O_CONFIG_COMPLETE,
  output logic O_CONFIG_COMPLETE_OE,
  input wire logic I_USER_STARTUP_CLOCK,
  input wire logic I_USER_CLOCK_SELECT,
  output logic [WORD_W-1:0] O_CFG_WORD,
  output logic O_CFG_VALID,
  input wire logic I_CFG_READY,
  output logic O_USER_MODE,
  output logic O_ERROR
);
  import pscfg_pkg::*;

  // ----------------------------------------------------------------------------
  // Link domain: serial shifter on the configuration clock
  // ----------------------------------------------------------------------------
  localparam int unsigned BW = (WORD_W > 1) ? $clog2(WORD_W) : 1;

  logic accept_ff;
  logic acc_meta_ff;
  logic acc_sync_ff;
  logic [BW-1:0] bit_cnt_ff;
  logic [WORD_W-1:0] shift_ff;
  logic [WORD_W-1:0] hold_ff;
  logic word_tog_ff;
  wire [WORD_W-1:0] shift_in = {I_DATA, shift_ff[WORD_W-1:1]};
  wire word_last = bit_cnt_ff == BW'(WORD_W - 1);

  // Accept level crosses in on two flops and clears them at once when it drops:
  // the link clock stops between frames, so a stale high would shift lead edges
  wire acc_clr_n = I_RST_N && accept_ff;
  always_ff @(posedge I_CONFIG_CLOCK or negedge acc_clr_n) begin
    if (!acc_clr_n) begin
      acc_meta_ff <= 1'b0;
      acc_sync_ff <= 1'b0;
    end else begin
      acc_meta_ff <= accept_ff;
      acc_sync_ff <= acc_meta_ff;
    end
  end

  // Bits taken on every rising edge once accept has crossed, first bit lands in the word LSB
  always_ff @(posedge I_CONFIG_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bit_cnt_ff <= '0;
      shift_ff <= '0;
      hold_ff <= '0;
      word_tog_ff <= 1'b0;
    end else if (!acc_sync_ff) begin
      bit_cnt_ff <= '0; // RL6
    end else begin
      shift_ff <= shift_in; // RL9
      bit_cnt_ff <= word_last ? '0 : bit_cnt_ff + BW'(1);
      if (word_last) begin
        hold_ff <= shift_in;
        word_tog_ff <= !word_tog_ff;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Core domain synchronisers
  // ----------------------------------------------------------------------------
  logic [4:0] pin_meta_ff;
  logic [4:0] pin_sync_ff;
  logic tog_seen_ff;
  logic uclk_prev_ff;

  // Pins and the word toggle each pass two flops before use
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_meta_ff <= 5'h07;
      pin_sync_ff <= 5'h07;
      tog_seen_ff <= 1'b0;
      uclk_prev_ff <= 1'b0;
    end else begin
      pin_meta_ff <= {word_tog_ff, I_USER_STARTUP_CLOCK, I_CONFIG_COMPLETE, I_STATUS_N,
                      I_CONFIG_REQUEST_N};
      pin_sync_ff <= pin_meta_ff;
      tog_seen_ff <= pin_sync_ff[4];
      uclk_prev_ff <= pin_sync_ff[3];
    end
  end

  wire req_high = pin_sync_ff[0];
  wire status_high = pin_sync_ff[1];
  wire complete_high = pin_sync_ff[2];
  wire uclk_rise = pin_sync_ff[3] && !uclk_prev_ff;
  wire word_evt = pin_sync_ff[4] != tog_seen_ff;

  // ----------------------------------------------------------------------------
  // Word FIFO toward the loader
  // ----------------------------------------------------------------------------
  seq_state_t state_ff;
  logic fifo_in_ready;
  wire push_req = word_evt && (state_ff == ST_RECEIVE);

  // hold_ff is stable here: the next word needs WORD_W link edges
  pscfg_word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_valid(push_req),
    .o_ready(fifo_in_ready),
    .i_data(hold_ff),
    .o_valid(O_CFG_VALID),
    .i_ready(I_CFG_READY),
    .o_data(O_CFG_WORD)
  );

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  seq_state_t nxt_state;
  logic req_prev_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] wcnt_ff;
  logic [CNT_W-1:0] nxt_wcnt;
  logic user_sel_ff;
  od_drive_t status_drv;
  od_drive_t complete_drv;

  wire req_fall = req_prev_ff && !req_high;
  wire pop = O_CFG_VALID && I_CFG_READY;
  wire last_pop = pop && (wcnt_ff == CNT_W'(BITSTREAM_WORDS - 1));
  wire status_min_done = cnt_ff >= CNT_W'(STATUS_MIN_CYC);
  wire cu_done = cnt_ff >= CNT_W'(CU_WAIT_CYC);
  wire osc_done = cnt_ff >= CNT_W'(INIT_OSC_CYC);
  wire user_done = cnt_ff >= CNT_W'(USER_INIT_CYCLES);
  wire overrun = push_req && !fifo_in_ready;
  wire init_tick = user_sel_ff ? uclk_rise : 1'b1;
  wire init_done = user_sel_ff ? user_done : osc_done;

  // Status and complete are open drain: low while driven, released otherwise
  assign status_drv.out = 1'b0;
  assign status_drv.oe = (state_ff == ST_CLEAR) || (state_ff == ST_FAULT); // RL3
  assign complete_drv.out = 1'b0;
  assign complete_drv.oe = (state_ff == ST_CLEAR) || (state_ff == ST_RELEASE) ||
                           (state_ff == ST_RECEIVE) || (state_ff == ST_FAULT); // RL2
  assign O_STATUS_N = status_drv.out;
  assign O_STATUS_N_OE = status_drv.oe;
  assign O_CONFIG_COMPLETE = complete_drv.out;
  assign O_CONFIG_COMPLETE_OE = complete_drv.oe;
  assign O_USER_MODE = state_ff == ST_USER;
  assign O_ERROR = state_ff == ST_FAULT;

  // Next state; a request fall overrides everything and restarts the cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_wcnt = wcnt_ff;
    if (req_fall) begin
      nxt_state = ST_CLEAR; // RL2 RL3
      nxt_cnt = '0;
    end else begin
      unique case (state_ff)
        ST_CLEAR: begin
          if (!status_min_done) begin
            nxt_cnt = cnt_ff + CNT_W'(1);
          end else if (req_high) begin
            nxt_state = ST_RELEASE; // RL4 RL5
          end
        end
        ST_RELEASE: begin
          // Either pin held low externally postpones the data phase
          if (req_high && status_high) begin
            nxt_state = ST_RECEIVE; // RL6
            nxt_wcnt = '0;
          end
        end
        ST_RECEIVE: begin
          if (overrun) begin
            nxt_state = ST_FAULT;
          end else if (last_pop) begin
            nxt_state = user_sel_ff ? ST_CU_WAIT : ST_INIT; // RL14 RL13
            nxt_cnt = '0;
          end else if (pop) begin
            nxt_wcnt = wcnt_ff + CNT_W'(1);
          end
        end
        ST_CU_WAIT: begin
          if (!complete_high) begin
            nxt_cnt = '0;
          end else if (cu_done) begin
            nxt_state = ST_INIT; // RL11
            nxt_cnt = '0;
          end else begin
            nxt_cnt = cnt_ff + CNT_W'(1);
          end
        end
        ST_INIT: begin
          // Counting starts once the pin is seen high, not on the release
          if (!complete_high) begin
            nxt_cnt = '0;
          end else if (init_done) begin
            nxt_state = ST_USER; // RL10 RL11 RL12
          end else if (init_tick) begin
            nxt_cnt = cnt_ff + CNT_W'(1);
          end
        end
        ST_USER: begin
          nxt_state = ST_USER;
        end
        ST_FAULT: begin
          nxt_state = ST_FAULT;
        end
        default: begin
          nxt_state = ST_CLEAR;
          nxt_cnt = '0;
        end
      endcase
    end
  end

  // State registers; power-up starts a configuration cycle
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_ff <= ST_CLEAR;
      cnt_ff <= '0;
      wcnt_ff <= '0;
      req_prev_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      wcnt_ff <= nxt_wcnt;
      req_prev_ff <= req_high;
    end
  end

  // Start-up clock option is latched as the data phase opens
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      user_sel_ff <= 1'b0;
      accept_ff <= 1'b0;
    end else begin
      if (state_ff == ST_RELEASE) begin
        user_sel_ff <= I_USER_CLOCK_SELECT; // RL13
      end
      accept_ff <= nxt_state == ST_RECEIVE; // RL6
    end
  end

endmodule : passive_serial_config_sequencer
`default_nettype wire

//--- pkg/pscfg_pkg.sv
// Constants, states and carrier types for the passive serial configuration sequencer
`default_nettype none
package pscfg_pkg;

  // ----------------------------------------------------------------------------
  // Clock and word sizes
  // ----------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;      // Core clock I_CLK, 10 MHz
  localparam int unsigned WORD_W = 32;              // Serial bits packed per configuration word
  localparam int unsigned FIFO_DEPTH = 8;           // Words buffered toward the loader
  localparam int unsigned BITSTREAM_WORDS = 16;     // Default bitstream length in words
  localparam int unsigned CNT_W = 16;               // Width of the sequencing counters

  // ----------------------------------------------------------------------------
  // Timing figures in their own units, and derived cycle counts
  // ----------------------------------------------------------------------------
  localparam int unsigned T_CF2ST_MAX_NS = 600;     // Request low to status and complete low
  localparam int unsigned T_STATUS_MIN_US = 268;    // Least status low time
  localparam int unsigned T_STATUS_MAX_US = 1506;   // Longest status low time
  localparam int unsigned T_INIT_OSC_MIN_US = 175;  // Least complete-high to user mode, oscillator
  localparam int unsigned T_INIT_OSC_MAX_US = 437;  // Longest complete-high to user mode, oscillator
  localparam int unsigned CFG_CLK_MAX_MHZ = 125;    // Highest configuration clock rate
  localparam int unsigned CU_WAIT_PERIODS = 4;      // Max config clock periods before user clock
  localparam int unsigned USER_INIT_CYCLES = 8576;  // User start-up clock periods to user mode
  localparam int unsigned OSC_MAX_MHZ_X10 = 125;    // Internal oscillator ceiling, 12.5 MHz

  // Least times round up, none below one cycle
  localparam int unsigned STATUS_MIN_CYC =
    (T_STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STATUS_MAX_CYC = (T_STATUS_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned INIT_OSC_CYC =
    (T_INIT_OSC_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CU_WAIT_NS = (CU_WAIT_PERIODS * 1000) / CFG_CLK_MAX_MHZ;
  localparam int unsigned CU_WAIT_RAW = (CU_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CU_WAIT_CYC = (CU_WAIT_RAW < 1) ? 1 : CU_WAIT_RAW;

  // ----------------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_CLEAR   = 3'b000,  // Status and complete driven low
    ST_RELEASE = 3'b001,  // Status released, waiting for both pins high
    ST_RECEIVE = 3'b010,  // Accepting serial data
    ST_CU_WAIT = 3'b011,  // Delay before the user start-up clock is enabled
    ST_INIT    = 3'b100,  // Initialization clock count
    ST_USER    = 3'b101,  // User mode
    ST_FAULT   = 3'b110   // Overrun, status held low until a new request
  } seq_state_t;

  // Drive pair of an open-drain pin
  typedef struct packed {
    logic out;
    logic oe;
  } od_drive_t;

endpackage : pscfg_pkg
`default_nettype wire

//--- dv/pscfg_seq_asserts.sv
// Pin timing checker for the configuration sequencer
`timescale 1ns/100ps
`default_nettype none
module pscfg_seq_asserts
  import pscfg_pkg::*;
#(
  parameter int unsigned USER_INIT_CYCLES = 8576
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_CONFIG_REQUEST_N,
  input wire logic I_STATUS_N,
  input wire logic O_STATUS_N_OE,
  input wire logic I_CONFIG_COMPLETE,
  input wire logic O_CONFIG_COMPLETE_OE,
  input wire logic I_USER_STARTUP_CLOCK,
  input wire logic I_USER_CLOCK_SELECT,
  input wire logic O_CFG_VALID,
  input wire logic O_USER_MODE,
  input wire logic O_ERROR
);
  localparam int unsigned INIT_MAX_CYC = T_INIT_OSC_MAX_US * 1000 / CLK_PERIOD_NS;
  logic [CNT_W-1:0] st_cnt_ff;
  logic [CNT_W-1:0] rq_cnt_ff;
  logic [CNT_W-1:0] cd_cnt_ff;
  logic [CNT_W-1:0] uc_cnt_ff;
  logic uc_q_ff;
  logic waiting;
  assign waiting = I_CONFIG_COMPLETE && !O_USER_MODE;
  // Counters restart when their condition ends, so one pin glitch cannot hide
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_cnt_ff <= '0;
      rq_cnt_ff <= '0;
      cd_cnt_ff <= '0;
      uc_cnt_ff <= '0;
      uc_q_ff <= 1'b0;
    end else begin
      st_cnt_ff <= O_STATUS_N_OE ? st_cnt_ff + 1'b1 : '0;
      rq_cnt_ff <= (I_CONFIG_REQUEST_N && O_STATUS_N_OE && !O_ERROR) ? rq_cnt_ff + 1'b1 : '0;
      cd_cnt_ff <= waiting ? cd_cnt_ff + 1'b1 : '0;
      uc_cnt_ff <= waiting ? uc_cnt_ff + {15'h0, I_USER_STARTUP_CLOCK && !uc_q_ff} : '0;
      uc_q_ff <= I_USER_STARTUP_CLOCK;
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_cmpl_pull; ##[1:6] O_CONFIG_COMPLETE_OE; endsequence
  sequence s_stat_pull; ##[1:6] O_STATUS_N_OE; endsequence
  cmpl_pull_a: assert property ($fell(I_CONFIG_REQUEST_N) |-> s_cmpl_pull)
    else $error("complete not pulled low in time");
  stat_pull_a: assert property ($fell(I_CONFIG_REQUEST_N) |-> s_stat_pull)
    else $error("status not pulled low in time");
  stat_min_a: assert property ($fell(O_STATUS_N_OE) |-> st_cnt_ff >= STATUS_MIN_CYC - 4)
    else $error("status low pulse too short");
  stat_release_a: assert property (rq_cnt_ff <= STATUS_MAX_CYC)
    else $error("status held too long after request high");
  no_early_a: assert property ($rose(O_CFG_VALID) |-> I_STATUS_N && I_CONFIG_REQUEST_N)
    else $error("word accepted while a pin was low");
  cmpl_hold_a: assert property (O_CFG_VALID |-> O_CONFIG_COMPLETE_OE)
    else $error("complete released with words pending");
  osc_init_a: assert property ($rose(O_USER_MODE) && !I_USER_CLOCK_SELECT |->
    cd_cnt_ff >= INIT_OSC_CYC && cd_cnt_ff <= INIT_MAX_CYC)
    else $error("oscillator init time out of range");
  uclk_init_a: assert property ($rose(O_USER_MODE) && I_USER_CLOCK_SELECT |->
    uc_cnt_ff >= USER_INIT_CYCLES && uc_cnt_ff <= USER_INIT_CYCLES + 3)
    else $error("user clock init count wrong");
  user_hold_a: assert property ($fell(O_USER_MODE) |-> !I_CONFIG_REQUEST_N)
    else $error("user mode left without a request");
  user_free_a: assert property (O_USER_MODE |-> !O_STATUS_N_OE && !O_CONFIG_COMPLETE_OE)
    else $error("pin pulled low in user mode");
  fault_pull_a: assert property (O_ERROR |-> O_STATUS_N_OE && O_CONFIG_COMPLETE_OE)
    else $error("fault without status and complete low");
endmodule : pscfg_seq_asserts
bind passive_serial_config_sequencer pscfg_seq_asserts #(
  .USER_INIT_CYCLES(USER_INIT_CYCLES)
) i_pscfg_seq_asserts (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CONFIG_REQUEST_N(I_CONFIG_REQUEST_N),
  .I_STATUS_N(I_STATUS_N), .O_STATUS_N_OE(O_STATUS_N_OE),
  .I_CONFIG_COMPLETE(I_CONFIG_COMPLETE), .O_CONFIG_COMPLETE_OE(O_CONFIG_COMPLETE_OE),
  .I_USER_STARTUP_CLOCK(I_USER_STARTUP_CLOCK), .I_USER_CLOCK_SELECT(I_USER_CLOCK_SELECT),
  .O_CFG_VALID(O_CFG_VALID), .O_USER_MODE(O_USER_MODE), .O_ERROR(O_ERROR)
);
`default_nettype wire

//--- dv/pscfg_host_model.sv
// Configuration host model: request pin, link clock and serial data
`timescale 1ns/100ps
`default_nettype none
module pscfg_host_model
  import pscfg_pkg::*;
(
  output var logic o_request_n,
  output var logic o_config_clock,
  output var logic o_data
);
  // Link clock stands still outside frames
  initial begin
    o_request_n = 1'b1;
    o_config_clock = 1'b0;
    o_data = 1'b0;
  end
  // Caller times the low width; the bench keeps it well above 2 us
  task automatic set_request(input logic v);
    o_request_n = v;
  endtask : set_request
  // Two lead edges let the accept level cross into the link domain
  task automatic prime();
    repeat (2) begin
      #16 o_config_clock = 1'b1;
      #16 o_config_clock = 1'b0;
    end
  endtask : prime
  // 32 ns period; data turns to its inverse once hold ends, so stale bits never match
  task automatic send_word(input logic [WORD_W-1:0] w);
    for (int b = 0; b < WORD_W; b++) begin
      #8 o_data = w[b];
      #8 o_config_clock = 1'b1;
      #1 o_data = ~w[b];
      #15 o_config_clock = 1'b0;
    end
  endtask : send_word
endmodule : pscfg_host_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the configuration sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pscfg_pkg::*;
  localparam int unsigned N_WORDS = 4;
  localparam int unsigned UI_CYC = 16;
  logic clk, rst_n, ucclk, usel, ready, req_n, cclk, sdata;
  logic st_oe, st_drv, cd_oe, cd_drv, valid, umode, err;
  logic [WORD_W-1:0] word;
  int n_errors = 0;
  int tests_run = 0;
  // Open-drain wires with pull-ups
  wire logic status_n = st_oe ? st_drv : 1'b1;
  wire logic complete = cd_oe ? cd_drv : 1'b1;
  always #50 clk = ~clk;
  always #200 ucclk = ~ucclk;
  pscfg_host_model i_host (.o_request_n(req_n), .o_config_clock(cclk), .o_data(sdata));
  passive_serial_config_sequencer #(
    .BITSTREAM_WORDS(N_WORDS), .USER_INIT_CYCLES(UI_CYC)
  ) i_passive_serial_config_sequencer (
    .I_CLK(clk), .I_RST_N(rst_n), .I_CONFIG_CLOCK(cclk), .I_DATA(sdata),
    .I_CONFIG_REQUEST_N(req_n), .I_STATUS_N(status_n), .O_STATUS_N(st_drv),
    .O_STATUS_N_OE(st_oe), .I_CONFIG_COMPLETE(complete), .O_CONFIG_COMPLETE(cd_drv),
    .O_CONFIG_COMPLETE_OE(cd_oe), .I_USER_STARTUP_CLOCK(ucclk),
    .I_USER_CLOCK_SELECT(usel), .O_CFG_WORD(word), .O_CFG_VALID(valid),
    .I_CFG_READY(ready), .O_USER_MODE(umode), .O_ERROR(err)
  );
  // ----------------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset_pulse();
    int n;
    check("status pulled", 32'(st_oe), 32'h1);
    check("complete pulled", 32'(cd_oe), 32'h1);
    for (n = 0; n < 20000 && st_oe === 1'b1; n++) tick();
    check("status low min", 32'(n >= STATUS_MIN_CYC - 4), 32'h1);
    check("status low max", 32'(n <= STATUS_MAX_CYC), 32'h1);
    $display("Test reset pulse done");
  endtask : t_reset_pulse
  // Request from any state; low width 30 cycles, one and a half times the least
  task automatic t_request();
    int n;
    i_host.set_request(1'b0);
    for (n = 0; n < 10 && !(st_oe === 1'b1 && cd_oe === 1'b1); n++) tick();
    check("pull delay", 32'(n <= 6), 32'h1);
    repeat (30) tick();
    check("user mode left", 32'(umode), 32'h0);
    check("fault cleared", 32'(err), 32'h0);
    i_host.set_request(1'b1);
    for (n = 0; n < 20000 && st_oe === 1'b1; n++) tick();
    check("status released", 32'(n <= STATUS_MAX_CYC), 32'h1);
    $display("Test request done");
  endtask : t_request
  // Full load with the consumer stalled, then drained to empty
  task automatic t_load(input logic sel);
    int n;
    usel = sel;
    repeat (20) tick();
    i_host.prime();
    for (int k = 0; k < N_WORDS; k++) i_host.send_word(32'h5a3c0f00 + 32'(k));
    tick();
    for (int k = 0; k < N_WORDS; k++) begin
      for (n = 0; n < 10 && valid !== 1'b1; n++) tick();
      check("word", word, 32'h5a3c0f00 + 32'(k));
      check("complete held", 32'(cd_oe), 32'h1);
      ready = 1'b1;
      tick();
    end
    // Ready stays up across pops so it is never lowered and raised in one step
    ready = 1'b0;
    check("fifo empty", 32'(valid), 32'h0);
    tick();
    check("complete released", 32'(cd_oe), 32'h0);
    for (n = 0; n < 5000 && umode !== 1'b1; n++) tick();
    if (sel) begin
      check("user clock init", 32'(n >= UI_CYC * 4 - 4 && n <= UI_CYC * 4 + 12), 32'h1);
    end else begin
      check("osc init", 32'(n >= INIT_OSC_CYC && n <= 4370), 32'h1);
    end
    check("status free", 32'(status_n), 32'h1);
    $display("Test load done");
  endtask : t_load
  // FIFO filled to its depth, then one word more is refused as a fault
  task automatic t_overrun();
    // Host here waits the full span again, counted from the status release that t_request waited for
    repeat (STATUS_MAX_CYC) tick();
    i_host.prime();
    for (int k = 0; k < FIFO_DEPTH; k++) i_host.send_word(~(32'h0 + 32'(k)));
    repeat (8) tick();
    check("full no fault", 32'(err), 32'h0);
    check("first word", word, 32'hffffffff);
    i_host.send_word(32'h0f0f0f0f);
    repeat (8) tick();
    check("overrun fault", 32'(err), 32'h1);
    check("fault status", 32'(st_oe), 32'h1);
    $display("Test overrun done");
  endtask : t_overrun
  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ucclk = 1'b0;
    usel = 1'b0;
    ready = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    tick();
    t_reset_pulse();
    t_load(1'b0);
    t_request();
    t_load(1'b1);
    t_request();
    t_overrun();
    t_request();
    end_of_test();
  end
  // Watchdog: run needs about 28000 cycles, the overrun wait being the longest
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    $display("Watchdog expired");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
